// ==== dcc_buf2.sv ====
`timescale 1ns/1ps
module dcc_buf2 #(
   parameter int W = 32,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   dcc_strm_if.snk up,
   dcc_strm_if.src dn
);
   generate
      if (DEPTH != 2) begin : g_chk
         $error("dcc_buf2 supports exactly two entries");
      end
   endgenerate

   logic [W-1:0] mem_ff [2];
   logic wp_ff;
   logic rp_ff;
   logic [1:0] cnt_ff;
   logic push;
   logic pop;

   // Full and empty come straight from the count, so back-pressure is exact
   assign up.ready = (cnt_ff != 2'h2);
   assign dn.valid = (cnt_ff != 2'h0);
   assign dn.data = mem_ff[rp_ff];
   assign push = ce & up.valid & up.ready;
   assign pop = ce & dn.valid & dn.ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_ff[wp_ff] <= up.data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         if (push) begin
            wp_ff <= ~wp_ff;
         end
         if (pop) begin
            rp_ff <= ~rp_ff;
         end
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ==== dcc_dbg_model.sv ====
`timescale 1ns/1ps
module dcc_dbg_model import dcc_pkg::*; (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // Scan clock rests low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // One 64 ns scan cycle; tdo sampled late in the low phase, long after the fall
   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #16;
      q = tdo;
      tck = 1'b1;
      #32;
      tck = 1'b0;
      #16;
   endtask

   task automatic tap_reset();
      logic q;
      repeat (5) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b1, q);
   endtask

   task automatic load_ir(input logic [4:0] ir);
      logic q;
      tick(1'b1, 1'b0, q);
      tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b1, q);
      for (int i = 0; i < 5; i++) begin
         tick(i == 4, ir[i], q);
      end
      tick(1'b1, ~ir[4], q);
      tick(1'b0, ir[4], q);
   endtask

   // Every poll scans the whole register, so flag and data come out together
   task automatic scan_dr(input dcc_sreg_t din, output dcc_sreg_t dout);
      logic q;
      tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b1, q);
      tick(1'b0, 1'b0, q);
      for (int i = 0; i < 36; i++) begin
         tick(i == 35, din[i], dout[i]);
      end
      tick(1'b1, ~din[35], q);
      tick(1'b0, din[35], q);
   endtask
endmodule

// ==== dcc_defines.svh ====
// Operation
// RQ1: Scan write while receive-ready set raises overflow
// RQ2: Overflow sticky until handler writes handshake register
// RQ3: Download flag written only from scan port
// RQ4: Debugger sets download per word, clears at end
// RQ5: Debugger polls transmit-ready with data each scan
// RQ6: Scanning out valid transmit data clears transmit-ready
// RQ7: Handler transmit write sets transmit-ready
// RQ8: Bits 31..28 feed N Z C V
// RQ9: Handshake read at cp14 c14 c0 op0
// RQ10: Receive buffer read at cp14 c9
// RQ11: Transmit buffer guarded against overwriting unread data
// RQ12: Receive buffer guarded against overwriting unread word
// RQ13: Three scan instructions share 36-bit shift register
// RQ14: Update-DR loads selected data register
// RQ15: Code 01001 selects control/status register
// RQ16: Debugger reads all, writes scan-writable bits
// RQ17: Control/status select can request external break
// RQ18: Scan write sets receive-ready, handler read clears
// RQ19: Receive-ready bit 31, overflow bit 30
// RQ20: Code 10000 selects transmit-read register
// RQ21: Code 00010 selects receive-write register
// RQ22: Download bit 29, transmit-ready 28, rest zero
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_IR_SEL_CS 5'h09
`define DCC_IR_TX_READ 5'h10
`define DCC_IR_RX_WRITE 5'h02
`define DCC_IR_BYPASS 5'h1f
`define DCC_IR_CAPTURE 5'h01
`define DCC_HS_RR 31
`define DCC_HS_OV 30
`define DCC_HS_DL 29
`define DCC_HS_TR 28
`define DCC_CRN_TX 4'h8
`define DCC_CRN_RX 4'h9
`define DCC_CRN_DEBUG_CTRL_STATUS_REGISTER 4'ha
`define DCC_CRN_HS 4'he
`define DCC_SR_VALID 35
`define DCC_SR_DHI 34
`define DCC_SR_DLO 3
`define DCC_SR_DL 2
`define DCC_SR_BRK 2
`define DCC_SR_HOLD 1
`define DCC_SR_FLAG 0
`define DCC_DEBUG_CTRL_STATUS_REGISTER_RST 32'h00000000
`define DCC_DEBUG_CTRL_STATUS_REGISTER_WMASK 32'h800000ff
`endif

// ==== dcc_pkg.sv ====
package dcc_pkg;
   typedef enum logic [3:0] {
      st_tlr, st_rti, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr,
      st_upd_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir, st_upd_ir
   } dcc_tap_t;
   typedef logic [35:0] dcc_sreg_t;
endpackage

// ==== dcc_strm_if.sv ====
`timescale 1ns/1ps
interface dcc_strm_if #(parameter int W = 32);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

// ==== dcc_top.sv ====
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_top import dcc_pkg::*; #(
   parameter int DW = 32,
   parameter logic [31:0] DEBUG_CTRL_STATUS_REGISTER_WMASK = `DCC_DEBUG_CTRL_STATUS_REGISTER_WMASK
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   input wire logic cp_req_valid,
   output logic cp_req_ready,
   input wire logic cp_req_write,
   input wire logic [3:0] cp_req_crn,
   input wire logic [3:0] cp_req_crm,
   input wire logic [2:0] cp_req_op2,
   input wire logic [31:0] cp_req_wdata,
   output logic cp_rsp_valid,
   input wire logic cp_rsp_ready,
   output logic [31:0] cp_rsp_data,
   output logic [3:0] cp_rsp_nzcv,
   input wire logic dbg_exc_taken,
   output logic ext_break_req,
   output logic hold_reset,
   output logic [31:0] debug_ctrl_status_register_value
);
   generate
      if (DW != 32) begin : g_chk
         $error("dcc_top: data width must be 32");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and scan clock edges

   logic [2:0] tck_sy_ff;
   logic [1:0] tms_sy_ff;
   logic [1:0] tdi_sy_ff;
   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tck_sy_ff <= 3'h0;
         tms_sy_ff <= 2'h3;
         tdi_sy_ff <= 2'h0;
      end else if (ce) begin
         tck_sy_ff <= {tck_sy_ff[1:0], tck};
         tms_sy_ff <= {tms_sy_ff[0], tms};
         tdi_sy_ff <= {tdi_sy_ff[0], tdi};
      end
   end

   // Scan clock must be well below clk_sys/4 for edges to be seen
   assign tck_rise = tck_sy_ff[1] & ~tck_sy_ff[2];
   assign tck_fall = ~tck_sy_ff[1] & tck_sy_ff[2];
   assign tms_s = tms_sy_ff[1];
   assign tdi_s = tdi_sy_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   // Test access port state machine

   dcc_tap_t tap_ff;
   dcc_tap_t nxt_tap;

   always_comb begin
      unique case (tap_ff)
         st_tlr: nxt_tap = tms_s ? st_tlr : st_rti;
         st_rti: nxt_tap = tms_s ? st_sel_dr : st_rti;
         st_sel_dr: nxt_tap = tms_s ? st_sel_ir : st_cap_dr;
         st_cap_dr: nxt_tap = tms_s ? st_ex1_dr : st_sh_dr;
         st_sh_dr: nxt_tap = tms_s ? st_ex1_dr : st_sh_dr;
         st_ex1_dr: nxt_tap = tms_s ? st_upd_dr : st_pa_dr;
         st_pa_dr: nxt_tap = tms_s ? st_ex2_dr : st_pa_dr;
         st_ex2_dr: nxt_tap = tms_s ? st_upd_dr : st_sh_dr;
         st_upd_dr: nxt_tap = tms_s ? st_sel_dr : st_rti;
         st_sel_ir: nxt_tap = tms_s ? st_tlr : st_cap_ir;
         st_cap_ir: nxt_tap = tms_s ? st_ex1_ir : st_sh_ir;
         st_sh_ir: nxt_tap = tms_s ? st_ex1_ir : st_sh_ir;
         st_ex1_ir: nxt_tap = tms_s ? st_upd_ir : st_pa_ir;
         st_pa_ir: nxt_tap = tms_s ? st_ex2_ir : st_pa_ir;
         st_ex2_ir: nxt_tap = tms_s ? st_upd_ir : st_sh_ir;
         st_upd_ir: nxt_tap = tms_s ? st_sel_dr : st_rti;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tap_ff <= st_tlr;
      end else if (ce && tck_rise) begin
         tap_ff <= nxt_tap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register

   logic [4:0] ir_sr_ff;
   logic [4:0] ir_ff;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ir_sr_ff <= `DCC_IR_CAPTURE;
         ir_ff <= `DCC_IR_BYPASS;
      end else if (ce) begin
         if (tck_rise && tap_ff == st_cap_ir) begin
            ir_sr_ff <= `DCC_IR_CAPTURE;
         end else if (tck_rise && tap_ff == st_sh_ir) begin
            ir_sr_ff <= {tdi_s, ir_sr_ff[4:1]};
         end
         if (tck_fall && tap_ff == st_tlr) begin
            ir_ff <= `DCC_IR_BYPASS;
         end else if (tck_fall && tap_ff == st_upd_ir) begin
            ir_ff <= ir_sr_ff;
         end
      end
   end

   logic sel_cs;
   logic sel_tx;
   logic sel_rx;
   logic sel_dbg;
   assign sel_cs = (ir_ff == `DCC_IR_SEL_CS); // [RQ15]
   assign sel_tx = (ir_ff == `DCC_IR_TX_READ); // [RQ20]
   assign sel_rx = (ir_ff == `DCC_IR_RX_WRITE); // [RQ21]
   assign sel_dbg = sel_cs | sel_tx | sel_rx;

   ////////////////////////////////////////////////////////////////////////////
   // Shared debug shift register and scan-side events

   dcc_sreg_t sr_ff;
   logic byp_ff;
   logic tx_cap_ff;
   logic [31:0] tx_ff;
   logic [31:0] rx_ff;
   logic [31:0] debug_ctrl_status_register_ff;
   logic rr_ff;
   logic ov_ff;
   logic dl_ff;
   logic tr_ff;
   logic upd_dr;
   logic upd_cs;
   logic rx_write;
   logic tr_clr;

   assign upd_dr = ce & tck_fall & (tap_ff == st_upd_dr);
   assign upd_cs = upd_dr & sel_cs;
   // Only a word flagged valid is a write, so polling scans leave the buffer alone
   assign rx_write = upd_dr & sel_rx & sr_ff[`DCC_SR_VALID];
   // First shift after a capture that saw valid data consumes the word
   assign tr_clr = ce & tck_rise & (tap_ff == st_sh_dr) & sel_tx & tx_cap_ff; // [RQ6]

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sr_ff <= '0;
         byp_ff <= 1'b0;
      end else if (ce && tck_rise) begin
         if (tap_ff == st_cap_dr) begin
            byp_ff <= 1'b0;
            sr_ff <= '0;
            if (sel_cs) begin
               sr_ff[`DCC_SR_DHI:`DCC_SR_DLO] <= debug_ctrl_status_register_ff; // [RQ16]
               sr_ff[`DCC_SR_HOLD] <= 1'b1;
            end else if (sel_tx) begin
               sr_ff[`DCC_SR_DHI:`DCC_SR_DLO] <= tx_ff; // [RQ5]
               sr_ff[`DCC_SR_FLAG] <= tr_ff;
            end else if (sel_rx) begin
               sr_ff[`DCC_SR_FLAG] <= rr_ff;
            end
         end else if (tap_ff == st_sh_dr) begin
            sr_ff <= {tdi_s, sr_ff[35:1]}; // [RQ13]
            byp_ff <= tdi_s;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_cap_ff <= 1'b0;
      end else if (ce && tck_rise) begin
         if (tap_ff == st_cap_dr) begin
            tx_cap_ff <= sel_tx & tr_ff;
         end else if (tap_ff == st_sh_dr) begin
            tx_cap_ff <= 1'b0;
         end
      end
   end

   // Output changes on the falling scan edge so the debugger samples it on the rise
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (ce && tck_fall) begin
         tdo_oe <= (tap_ff == st_sh_dr) | (tap_ff == st_sh_ir);
         if (tap_ff == st_sh_ir) begin
            tdo <= ir_sr_ff[0];
         end else if (sel_dbg) begin
            tdo <= sr_ff[0];
         end else begin
            tdo <= byp_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control/status register, break request and hold-in-reset

   logic cp_take;
   logic cp_hit;
   logic hs_write;
   logic tx_write;
   logic rx_read;
   logic debug_ctrl_status_register_write;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         debug_ctrl_status_register_ff <= `DCC_DEBUG_CTRL_STATUS_REGISTER_RST;
      end else if (ce) begin
         if (upd_cs) begin
            debug_ctrl_status_register_ff <= (debug_ctrl_status_register_ff & ~DEBUG_CTRL_STATUS_REGISTER_WMASK) |
                       (sr_ff[`DCC_SR_DHI:`DCC_SR_DLO] & DEBUG_CTRL_STATUS_REGISTER_WMASK); // [RQ14] [RQ16]
         end else if (debug_ctrl_status_register_write) begin
            debug_ctrl_status_register_ff <= cp_req_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ext_break_req <= 1'b0;
         hold_reset <= 1'b0;
      end else if (ce) begin
         if (upd_cs) begin
            hold_reset <= sr_ff[`DCC_SR_HOLD];
         end
         // A new request beats a debug exception in the same cycle
         if (upd_cs && sr_ff[`DCC_SR_BRK]) begin
            ext_break_req <= 1'b1; // [RQ17]
         end else if (dbg_exc_taken) begin
            ext_break_req <= 1'b0;
         end
      end
   end

   assign debug_ctrl_status_register_value = debug_ctrl_status_register_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Handler coprocessor accesses

   dcc_strm_if #(.W(32)) rsp_in ();
   dcc_strm_if #(.W(32)) rsp_out ();
   logic [31:0] hs_val;
   logic [31:0] rd_val;

   assign cp_req_ready = rsp_in.ready;
   assign cp_take = ce & cp_req_valid & rsp_in.ready;
   assign cp_hit = (cp_req_crm == 4'h0) & (cp_req_op2 == 3'h0);
   assign hs_write = cp_take & cp_hit & cp_req_write & (cp_req_crn == `DCC_CRN_HS);
   // A transmit write while the old word is unread is dropped
   assign tx_write = cp_take & cp_hit & cp_req_write & (cp_req_crn == `DCC_CRN_TX) &
                     ~tr_ff; // [RQ11]
   assign rx_read = cp_take & cp_hit & ~cp_req_write & (cp_req_crn == `DCC_CRN_RX); // [RQ10]
   assign debug_ctrl_status_register_write = cp_take & cp_hit & cp_req_write & (cp_req_crn == `DCC_CRN_DEBUG_CTRL_STATUS_REGISTER);
   assign hs_val = {rr_ff, ov_ff, dl_ff, tr_ff, 28'h0000000}; // [RQ19] [RQ22]

   always_comb begin
      rd_val = 32'h00000000;
      if (cp_hit && !cp_req_write) begin
         unique case (cp_req_crn)
            `DCC_CRN_HS: rd_val = hs_val; // [RQ9]
            `DCC_CRN_RX: rd_val = rx_ff;
            `DCC_CRN_TX: rd_val = tx_ff;
            `DCC_CRN_DEBUG_CTRL_STATUS_REGISTER: rd_val = debug_ctrl_status_register_ff;
            default: rd_val = 32'h00000000;
         endcase
      end
   end

   assign rsp_in.valid = ce & cp_req_valid;
   assign rsp_in.data = rd_val;
   assign rsp_out.ready = cp_rsp_ready;
   assign cp_rsp_valid = rsp_out.valid;
   assign cp_rsp_data = rsp_out.data;
   assign cp_rsp_nzcv = rsp_out.data[31:28]; // [RQ8]

   dcc_buf2 #(.W(32), .DEPTH(2)) u_rsp_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .up(rsp_in),
      .dn(rsp_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Buffers and handshake flags; every hardware set wins over a clear

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_ff <= 32'h00000000;
      end else if (tx_write) begin
         tx_ff <= cp_req_wdata;
      end
   end

   // An unread receive word is kept; the late word is lost and flagged
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_ff <= 32'h00000000;
      end else if (rx_write && !rr_ff) begin
         rx_ff <= sr_ff[`DCC_SR_DHI:`DCC_SR_DLO]; // [RQ12] [RQ14]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rr_ff <= 1'b0;
      end else if (rx_write) begin
         rr_ff <= 1'b1; // [RQ18]
      end else if (rx_read) begin
         rr_ff <= 1'b0; // [RQ18]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ov_ff <= 1'b0;
      end else if (rx_write && rr_ff) begin
         ov_ff <= 1'b1; // [RQ1]
      end else if (hs_write) begin
         ov_ff <= 1'b0; // [RQ2]
      end
   end

   // Debugger drives it on every receive-write update; handler cannot touch it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dl_ff <= 1'b0;
      end else if (upd_dr && sel_rx) begin
         dl_ff <= sr_ff[`DCC_SR_DL]; // [RQ3] [RQ4]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tr_ff <= 1'b0;
      end else if (tx_write) begin
         tr_ff <= 1'b1; // [RQ7]
      end else if (tr_clr) begin
         tr_ff <= 1'b0; // [RQ6]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_ov_on_overrun: assert property (rx_write && rr_ff |=> ov_ff && $stable(rx_ff)) // [RQ1]
      else $error("overflow not raised on overrun");
   a_ov_sticky_hold: assert property (ov_ff && !hs_write |=> ov_ff) // [RQ2]
      else $error("overflow dropped without handler write");
   a_dl_scan_only: assert property (!(upd_dr && sel_rx) |=> $stable(dl_ff)) // [RQ3]
      else $error("download flag changed outside scan update");
   a_tr_scan_clear: assert property (tr_clr && !tx_write |=> !tr_ff) // [RQ6]
      else $error("transmit-ready not cleared by scan-out");
   a_tr_set_write: assert property (tx_write |=> tr_ff && tx_ff == $past(cp_req_wdata)) // [RQ7]
      else $error("transmit write did not load and flag");
   a_rr_rx_write: assert property (rx_write |=> rr_ff) // [RQ18]
      else $error("receive-ready not set by scan write");
   a_rr_read_clear: assert property (rx_read && !rx_write |=> !rr_ff) // [RQ18]
      else $error("receive-ready not cleared by handler read");
   a_sr_shift_in: assert property (ce && tck_rise && tap_ff == st_sh_dr
      |=> sr_ff[35] == $past(tdi_s) && sr_ff[34:0] == $past(sr_ff[35:1])) // [RQ13]
      else $error("shift register did not shift");
   a_cs_capture: assert property (ce && tck_rise && tap_ff == st_cap_dr && sel_cs
      |=> sr_ff[34:3] == $past(debug_ctrl_status_register_ff) && sr_ff[1]) // [RQ15]
      else $error("control/status capture wrong");
   a_cs_wmask: assert property (upd_cs
      |=> (debug_ctrl_status_register_ff & ~DEBUG_CTRL_STATUS_REGISTER_WMASK) == ($past(debug_ctrl_status_register_ff) & ~DEBUG_CTRL_STATUS_REGISTER_WMASK)) // [RQ16]
      else $error("scan wrote a protected control/status bit");
   a_hs_read_val: assert property (cp_take && !rsp_out.valid && cp_hit && !cp_req_write
      && cp_req_crn == `DCC_CRN_HS |=> cp_rsp_valid
      && cp_rsp_data == {$past(rr_ff), $past(ov_ff), $past(dl_ff), $past(tr_ff), 28'h0}) // [RQ9]
      else $error("handshake read value wrong");
endmodule

// ==== debug_comm_channel_tb_top.sv ====
`timescale 1ns/1ps
`include "dcc_defines.svh"
module debug_comm_channel_tb_top import dcc_pkg::*; ;
   logic clk_sys, rst_n, ce, tck, tms, tdi, tdo, tdo_oe, tdo_pin;
   logic cp_req_valid, cp_req_ready, cp_req_write, cp_rsp_valid, cp_rsp_ready;
   logic [3:0] cp_req_crn, cp_req_crm, cp_rsp_nzcv, nzcv_seen;
   logic [2:0] cp_req_op2;
   logic [31:0] cp_req_wdata, cp_rsp_data, debug_ctrl_status_register_value;
   logic dbg_exc_taken, ext_break_req, hold_reset;
   int fail_count = 0;
   int tests_run = 0;

   dcc_top dcc_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .cp_req_valid(cp_req_valid),
      .cp_req_ready(cp_req_ready), .cp_req_write(cp_req_write), .cp_req_crn(cp_req_crn),
      .cp_req_crm(cp_req_crm), .cp_req_op2(cp_req_op2), .cp_req_wdata(cp_req_wdata),
      .cp_rsp_valid(cp_rsp_valid), .cp_rsp_ready(cp_rsp_ready), .cp_rsp_data(cp_rsp_data),
      .cp_rsp_nzcv(cp_rsp_nzcv), .dbg_exc_taken(dbg_exc_taken),
      .ext_break_req(ext_break_req), .hold_reset(hold_reset), .debug_ctrl_status_register_value(debug_ctrl_status_register_value));

   // Released pin has no pull; the debugger sees the inverse so a late enable shows up
   assign tdo_pin = tdo_oe ? tdo : ~tdo;

   dcc_dbg_model dcc_dbg_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Request held until the edge that takes it; answer taken one edge later
   task automatic cp_xfer(input logic wr, input logic [3:0] crn, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      @(posedge clk_sys);
      #1;
      cp_req_valid = 1'b1;
      cp_req_write = wr;
      cp_req_crn = crn;
      cp_req_wdata = wd;
      n = 0;
      while (cp_req_ready !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (cp_req_ready !== 1'b1) begin
         fail_count++;
      end
      @(posedge clk_sys);
      #1;
      cp_req_valid = 1'b0;
      n = 0;
      while (cp_rsp_valid !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (cp_rsp_valid !== 1'b1) begin
         fail_count++;
      end
      rd = cp_rsp_data;
      nzcv_seen = cp_rsp_nzcv;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic hs_check(input logic [31:0] exp);
      logic [31:0] rd;
      cp_xfer(1'b0, `DCC_CRN_HS, 32'h0, rd);
      check(rd, exp);
      check(nzcv_seen, exp[31:28]);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_state();
      hs_check(32'h0);
      check({tdo_oe, ext_break_req, hold_reset}, 3'h0);
   endtask

   task automatic t_receive();
      dcc_sreg_t so;
      logic [31:0] rd;
      dcc_dbg_model_inst.load_ir(`DCC_IR_RX_WRITE);
      dcc_dbg_model_inst.scan_dr({1'b1, 32'h1234abcd, 1'b1, 2'h0}, so);
      check(so[0], 1'b0);
      hs_check(32'ha0000000);
      // Nonzero secondary register is a no-op: reads zero and leaves receive-ready set
      cp_req_crm = 4'h1;
      cp_xfer(1'b0, `DCC_CRN_RX, 32'h0, rd);
      cp_req_crm = 4'h0;
      check(rd, 32'h0);
      // Second word lands before the handler has read the first
      dcc_dbg_model_inst.scan_dr({1'b1, 32'h0badf00d, 1'b1, 2'h0}, so);
      check(so[0], 1'b1);
      hs_check(32'he0000000);
      cp_xfer(1'b0, `DCC_CRN_RX, 32'h0, rd);
      check(rd, 32'h1234abcd);
      hs_check(32'h60000000);
      cp_xfer(1'b1, `DCC_CRN_HS, 32'hffffffff, rd);
      hs_check(32'h20000000);
      dcc_dbg_model_inst.scan_dr({1'b0, 32'hffffffff, 1'b0, 2'h0}, so);
      hs_check(32'h0);
   endtask

   task automatic t_transmit();
      dcc_sreg_t so;
      logic [31:0] rd;
      dcc_dbg_model_inst.load_ir(`DCC_IR_TX_READ);
      dcc_dbg_model_inst.scan_dr(36'h0, so);
      check(so[0], 1'b0);
      cp_xfer(1'b1, `DCC_CRN_TX, 32'hc001d00d, rd);
      hs_check(32'h10000000);
      // Unread word must survive a second handler write
      cp_xfer(1'b1, `DCC_CRN_TX, 32'h55aa55aa, rd);
      dcc_dbg_model_inst.scan_dr(36'h0, so);
      check({so[34:3], so[0]}, {32'hc001d00d, 1'b1});
      hs_check(32'h0);
      dcc_dbg_model_inst.scan_dr(36'h0, so);
      check(so[0], 1'b0);
   endtask

   task automatic t_ctrl_status();
      dcc_sreg_t so;
      logic [31:0] rd;
      dcc_dbg_model_inst.load_ir(`DCC_IR_SEL_CS);
      dcc_dbg_model_inst.scan_dr({1'b0, 32'hffffffff, 1'b1, 1'b1, 1'b0}, so);
      check({so[34:3], so[1]}, {32'h0, 1'b1});
      check(debug_ctrl_status_register_value, 32'hffffffff & `DCC_DEBUG_CTRL_STATUS_REGISTER_WMASK);
      check({ext_break_req, hold_reset}, 2'h3);
      @(posedge clk_sys);
      #1;
      dbg_exc_taken = 1'b1;
      @(posedge clk_sys);
      #1;
      dbg_exc_taken = 1'b0;
      @(posedge clk_sys);
      #1;
      check(ext_break_req, 1'b0);
      dcc_dbg_model_inst.scan_dr(36'h0, so);
      check(so[34:3], 32'hffffffff & `DCC_DEBUG_CTRL_STATUS_REGISTER_WMASK);
      check({debug_ctrl_status_register_value, hold_reset}, 33'h0);
      // Handler sets protected bits; the scan must read them and leave them alone
      cp_xfer(1'b1, `DCC_CRN_DEBUG_CTRL_STATUS_REGISTER, 32'h0000a5c3, rd);
      dcc_dbg_model_inst.scan_dr(36'h0, so);
      check(so[34:3], 32'h0000a5c3);
      check(debug_ctrl_status_register_value, 32'h0000a5c3 & ~`DCC_DEBUG_CTRL_STATUS_REGISTER_WMASK);
   endtask

   // Receiver stalls: two responses fill the buffer, the third request is held off
   task automatic t_resp_buffer();
      @(posedge clk_sys);
      #1;
      cp_rsp_ready = 1'b0;
      cp_req_valid = 1'b1;
      cp_req_write = 1'b0;
      cp_req_crn = `DCC_CRN_HS;
      repeat (2) @(posedge clk_sys);
      #1;
      check({cp_req_ready, cp_rsp_valid}, 2'h1);
      // Clock enable low must freeze the full buffer even with the receiver ready
      ce = 1'b0;
      cp_rsp_ready = 1'b1;
      @(posedge clk_sys);
      #1;
      check({cp_req_ready, cp_rsp_valid}, 2'h1);
      ce = 1'b1;
      @(posedge clk_sys);
      #1;
      check({cp_req_ready, cp_rsp_valid, cp_rsp_data}, {2'h3, 32'h0});
      @(posedge clk_sys);
      #1;
      cp_req_valid = 1'b0;
      check(cp_rsp_valid, 1'b1);
      @(posedge clk_sys);
      #1;
      check(cp_rsp_valid, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      cp_req_valid = 1'b0;
      cp_req_write = 1'b0;
      cp_req_crn = 4'h0;
      cp_req_crm = 4'h0;
      cp_req_op2 = 3'h0;
      cp_req_wdata = 32'h0;
      cp_rsp_ready = 1'b1;
      dbg_exc_taken = 1'b0;
      repeat (20) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      t_reset_state();
      dcc_dbg_model_inst.tap_reset();
      t_receive();
      t_transmit();
      t_ctrl_status();
      t_resp_buffer();
      tally_and_finish();
   end

   // Whole run is about 26 us of scan traffic
   initial begin
      #200000;
      fail_count++;
      tally_and_finish();
   end
endmodule
